// ==== inc/svps_params.svh ====
// svps_params.svh: register map, reset values and timing constants of the sequence voltage stage
`ifndef SVPS_PARAMS_SVH
`define SVPS_PARAMS_SVH
// register byte addresses
`define SVPS_A_CTRL     8'h00
`define SVPS_A_BANK0    8'h04
`define SVPS_A_BANK1    8'h08
`define SVPS_A_DT       8'h0c
`define SVPS_A_TIMING   8'h10
`define SVPS_A_PRIMNOM  8'h14
`define SVPS_CFG_END    8'h18
`define SVPS_A_STATUS   8'h20
`define SVPS_A_MEAS     8'h24
`define SVPS_A_EXPECT   8'h28
`define SVPS_A_REMAIN   8'h2c
`define SVPS_A_PRIMPU   8'h30
// ctrl field positions
`define SVPS_B_NEG      0
`define SVPS_B_UNDER0   1
`define SVPS_B_UNDER1   2
`define SVPS_B_IDMT     3
`define SVPS_B_RELEN    4
`define SVPS_B_FORCE    5
`define SVPS_B_FSEL     6
`define SVPS_B_MODE     8
// reset values
`define SVPS_RST_CTRL    32'h0000_0010
`define SVPS_RST_BANK    32'h01f4_2904
`define SVPS_RST_DT      32'h0000_0008
`define SVPS_RST_TIMING  32'h000c_0005
`define SVPS_RST_PRIMNOM 32'h0001_86a0
// arithmetic constants
`define SVPS_PCT_ONE    24'h64
`define SVPS_PCT_OVER   24'h61
`define SVPS_PCT_UNDER  24'h67
`define SVPS_SQRT3_Q15  16'sh6eda
`define SVPS_THIRD_Q15  16'sh2aab
`define SVPS_TIME_SCALE 24'hc8
`define SVPS_PRIM_DIV   40'h27_10
// timing: 5 ms time step at a 10 ns clock, 1800 s ceiling in steps
`define SVPS_TICK_NS    32'h004c_4b40
`define SVPS_CLK_NS     32'h0000_000a
`define SVPS_MAX_TICKS  19'h5_7e40
// bus responses
`define SVPS_OKAY       2'h0
`define SVPS_SLVERR     2'h2
`endif

// ==== inc/svps_pkg.sv ====
// svps_pkg.sv: types of the sequence voltage stage
package svps_pkg;
  typedef enum logic [2:0] {SVPS_IDLE, SVPS_SUM, SVPS_SQRT, SVPS_DIVR, SVPS_EVAL, SVPS_DIVT} svps_phase_e;
  typedef enum logic [2:0] {SVPS_ON, SVPS_BLOCKED, SVPS_TEST, SVPS_TEST_BLK, SVPS_OFF} svps_mode_e;
  typedef enum logic [1:0] {SVPS_F_NORMAL, SVPS_F_START, SVPS_F_TRIP, SVPS_F_BLOCKED} svps_force_e;
  typedef struct packed {
    svps_phase_e      st;
    logic [5:0]       bit_idx;
    logic [23:0]      acc;
    logic [35:0]      tgt;
    logic [18:0]      den;
    logic [2:0][15:0] ph_re;
    logic [2:0][15:0] ph_im;
    logic [15:0]      mag;
    logic [15:0]      ratio;
    logic             all_above;
    logic             pickup;
    logic             under_block_level;
    logic [5:0][31:0] cfg;
    logic [18:0]      expected;
    logic [18:0]      elapsed;
    logic [15:0]      rel_cnt;
    logic             releasing;
    logic             start;
    logic             trip;
    logic             blocked;
    logic [19:0]      tick_cnt;
    logic             tick;
    logic [31:0]      prim;
    logic             pickup_o;
    logic             start_o;
    logic             trip_o;
    logic             blocked_o;
    logic             awready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
  } svps_state_s;
endpackage

// ==== verilog/svps_stage.sv ====
// svps_stage.sv: sequence voltage protection stage with an AXI4-Lite register slave
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "svps_params.svh"

module svps_stage
  import svps_pkg::*;
#(
  parameter int TICK_CYCLES = `SVPS_TICK_NS / `SVPS_CLK_NS
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write channels
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read channels
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // fundamental phasors from the measurement block
  input  wire logic signed [15:0] l1_re,
  input  wire logic signed [15:0] l1_im,
  input  wire logic signed [15:0] l2_re,
  input  wire logic signed [15:0] l2_im,
  input  wire logic signed [15:0] l3_re,
  input  wire logic signed [15:0] l3_im,
  input  wire logic              phasor_valid,
  // system inputs
  input  wire logic              block_in,
  input  wire logic              active_group,
  // stage status
  output logic                   pickup,
  output logic                   start,
  output logic                   trip,
  output logic                   blocked
);

  // ****************************************
  // helpers
  // ****************************************
  // rotate a phasor by 120 or 240 degrees; result packed {re, im}
  function automatic logic [35:0] rot(input logic signed [15:0] x, input logic signed [15:0] y,
                                      input logic by240);
    logic signed [31:0] sx, sy;
    logic signed [17:0] hx, hy;
    logic signed [17:0] tx, ty;
    sx = x * `SVPS_SQRT3_Q15;
    sy = y * `SVPS_SQRT3_Q15;
    hx = 18'(x >>> 1);
    hy = 18'(y >>> 1);
    tx = 18'(sx >>> 15);
    ty = 18'(sy >>> 15);
    if (!by240) begin
      rot = {18'(-hx - ty), 18'(tx - hy)};
    end else begin
      rot = {18'(-hx + ty), 18'(-tx - hy)};
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
    merge = old;
  endfunction

  svps_state_s q;
  svps_state_s d;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [31:0]        ctrl, bank;
    logic [15:0]        lvl, blk;
    logic               under;
    logic               neg;
    svps_mode_e         mode;
    logic               blk_eff;
    logic               active;
    logic [35:0]        r2, r3;
    logic signed [17:0] sre, sim;
    logic signed [33:0] pre, pim;
    logic signed [17:0] sre3, sim3;
    logic [32:0]        psq;
    logic [32:0]        lvl2;
    logic               above;
    logic [23:0]        cand;
    logic [47:0]        prod;
    logic [23:0]        acc_n;
    logic [15:0]        mag_n;
    logic [23:0]        m100;
    logic [18:0]        dt_c;
    logic [15:0]        dev;
    logic [31:0]        rd;
    logic [1:0]         rr;
    d = q;
    ctrl = q.cfg[0];
    bank = active_group ? q.cfg[2] : q.cfg[1];
    lvl = bank[15:0];
    blk = bank[31:16];
    under = active_group ? ctrl[`SVPS_B_UNDER1] : ctrl[`SVPS_B_UNDER0];
    neg = ctrl[`SVPS_B_NEG];
    mode = (ctrl[`SVPS_B_MODE +: 3] > 3'h4) ? SVPS_OFF : svps_mode_e'(ctrl[`SVPS_B_MODE +: 3]);
    blk_eff = block_in || mode == SVPS_BLOCKED || mode == SVPS_TEST_BLK;
    active = q.pickup && !blk_eff && mode != SVPS_OFF;

    // 5 ms time step; a tick rather than a second clock keeps one domain
    d.tick = 1'b0;
    if (q.tick_cnt == 20'(TICK_CYCLES - 1)) begin
      d.tick_cnt = 20'h0;
      d.tick = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 20'h1;
    end

    // ****************************************
    // axi4-lite slave
    // ****************************************
    d.awready = s_axi_awvalid && s_axi_wvalid && !q.awready && !q.bvalid;
    if (q.awready) begin
      d.bvalid = 1'b1;
      d.bresp = `SVPS_SLVERR;
      if (s_axi_awaddr < `SVPS_CFG_END && s_axi_awaddr[1:0] == 2'h0) begin
        d.cfg[s_axi_awaddr[4:2]] = merge(q.cfg[s_axi_awaddr[4:2]], s_axi_wdata, s_axi_wstrb);
        d.bresp = `SVPS_OKAY;
      end
    end else if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    rd = 32'h0;
    rr = `SVPS_OKAY;
    if (s_axi_araddr < `SVPS_CFG_END && s_axi_araddr[1:0] == 2'h0) begin
      rd = q.cfg[s_axi_araddr[4:2]];
    end else if (s_axi_araddr == `SVPS_A_STATUS) begin
      rd = {23'h0, active_group, 3'(mode), q.under_block_level, q.blocked_o, q.trip_o, q.start_o, q.pickup};
    end else if (s_axi_araddr == `SVPS_A_MEAS) begin
      rd = {q.ratio, q.mag};
    end else if (s_axi_araddr == `SVPS_A_EXPECT) begin
      rd = {13'h0, q.expected};
    end else if (s_axi_araddr == `SVPS_A_REMAIN) begin
      rd = 32'($signed({1'b0, q.expected}) - $signed({1'b0, q.elapsed}));
    end else if (s_axi_araddr == `SVPS_A_PRIMPU) begin
      rd = q.prim;
    end else begin
      rr = `SVPS_SLVERR;
    end
    d.arready = s_axi_arvalid && !q.arready && !q.rvalid;
    if (q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = rd;
      d.rresp = rr;
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // ****************************************
    // measurement sequencer
    // ****************************************
    r2 = rot($signed(q.ph_re[1]), $signed(q.ph_im[1]), neg);
    r3 = rot($signed(q.ph_re[2]), $signed(q.ph_im[2]), !neg);
    sre = $signed({{2{q.ph_re[0][15]}}, q.ph_re[0]}) + $signed(r2[35:18]) + $signed(r3[35:18]);
    sim = $signed({{2{q.ph_im[0][15]}}, q.ph_im[0]}) + $signed(r2[17:0]) + $signed(r3[17:0]);
    pre = sre * `SVPS_THIRD_Q15;
    pim = sim * `SVPS_THIRD_Q15;
    sre3 = pre[32:15];
    sim3 = pim[32:15];
    lvl2 = 33'(lvl) * 33'(lvl);
    above = 1'b1;
    for (int i = 0; i < 3; i++) begin
      psq = 33'(32'($signed(q.ph_re[i])) * 32'($signed(q.ph_re[i]))) +
            33'(32'($signed(q.ph_im[i])) * 32'($signed(q.ph_im[i])));
      above = above && (psq > lvl2);
    end
    // one shared bit-serial search serves square root and both divisions
    cand = q.acc | (24'h1 << q.bit_idx);
    prod = (q.st == SVPS_SQRT) ? 48'(cand) * 48'(cand) : 48'(cand) * 48'(q.den);
    acc_n = (prod <= 48'(q.tgt)) ? cand : q.acc;
    mag_n = (|acc_n[23:16]) ? 16'hffff : acc_n[15:0];
    m100 = 24'(q.mag) * `SVPS_PCT_ONE;
    dt_c = (q.cfg[3][18:0] > `SVPS_MAX_TICKS) ? `SVPS_MAX_TICKS : q.cfg[3][18:0];
    dev = (q.ratio >= 16'h64) ? q.ratio - 16'h64 : 16'h64 - q.ratio;
    d.prim = 32'((40'(lvl) * 40'(q.cfg[5][23:0])) / `SVPS_PRIM_DIV);

    case (q.st)
      SVPS_IDLE: begin
        if (phasor_valid) begin
          d.ph_re = {l3_re, l2_re, l1_re};
          d.ph_im = {l3_im, l2_im, l1_im};
          d.st = SVPS_SUM;
        end
      end
      SVPS_SUM: begin
        d.tgt = 36'(sre3) * 36'(sre3) + 36'(sim3) * 36'(sim3);
        d.all_above = above;
        d.acc = 24'h0;
        d.bit_idx = 6'h11;
        d.st = SVPS_SQRT;
      end
      SVPS_SQRT: begin
        d.acc = acc_n;
        d.bit_idx = q.bit_idx - 6'h1;
        if (q.bit_idx == 6'h0) begin
          d.mag = mag_n;
          d.tgt = 36'(mag_n) * 36'h64;
          d.den = 19'(lvl);
          d.acc = 24'h0;
          d.bit_idx = 6'h17;
          d.st = SVPS_DIVR;
        end
      end
      SVPS_DIVR: begin
        d.acc = acc_n;
        d.bit_idx = q.bit_idx - 6'h1;
        if (q.bit_idx == 6'h0) begin
          d.ratio = (|acc_n[23:16]) ? 16'hffff : acc_n[15:0];
          d.st = SVPS_EVAL;
        end
      end
      SVPS_EVAL: begin
        if (mode == SVPS_OFF) begin
          d.pickup = 1'b0;
        end else if (!under) begin
          d.pickup = q.pickup ? !(m100 < 24'(lvl) * `SVPS_PCT_OVER) : (q.mag > lvl);
        end else begin
          d.pickup = q.pickup ? !(m100 > 24'(lvl) * `SVPS_PCT_UNDER) : (q.mag < lvl);
        end
        if (!under || blk == 16'h0) begin
          d.under_block_level = 1'b0;
        end else if (q.mag < blk) begin
          d.under_block_level = 1'b1;
        end else if (q.all_above) begin
          d.under_block_level = 1'b0;
        end
        if (ctrl[`SVPS_B_IDMT]) begin
          d.tgt = 36'(24'(q.cfg[4][15:0]) * `SVPS_TIME_SCALE);
          d.den = 19'(dev);
          d.acc = 24'h0;
          d.bit_idx = 6'h17;
          d.st = SVPS_DIVT;
        end else begin
          d.expected = dt_c;
          d.st = SVPS_IDLE;
        end
      end
      SVPS_DIVT: begin
        d.acc = acc_n;
        d.bit_idx = q.bit_idx - 6'h1;
        if (q.bit_idx == 6'h0) begin
          d.expected = (acc_n > 24'(`SVPS_MAX_TICKS)) ? `SVPS_MAX_TICKS : acc_n[18:0];
          d.st = SVPS_IDLE;
        end
      end
      default: d.st = SVPS_IDLE;
    endcase

    // ****************************************
    // start, release and trip timing
    // ****************************************
    if (active) begin                                        // off never counts
      d.start = 1'b1;
      d.releasing = 1'b0;
      d.rel_cnt = 16'h0;
      if (q.tick && q.elapsed < q.expected) begin
        d.elapsed = q.elapsed + 19'h1;
      end
    end else if (mode != SVPS_OFF && (q.start || q.releasing) && ctrl[`SVPS_B_RELEN] &&
                 q.rel_cnt < q.cfg[4][31:16]) begin
      // operating time is held, not cleared, while the release runs
      d.releasing = 1'b1;
      d.start = !blk_eff;
      if (q.tick) begin
        d.rel_cnt = q.rel_cnt + 16'h1;
      end
    end else begin
      d.start = 1'b0;
      d.releasing = 1'b0;
      d.elapsed = 19'h0;
      d.rel_cnt = 16'h0;
    end
    d.trip = active && q.elapsed >= q.expected && !q.under_block_level;
    d.blocked = q.pickup && blk_eff && mode != SVPS_OFF;

    if (ctrl[`SVPS_B_FORCE]) begin
      d.pickup_o = 1'b0;
      d.start_o = 1'b0;
      d.trip_o = 1'b0;
      d.blocked_o = 1'b0;
      case (svps_force_e'(ctrl[`SVPS_B_FSEL +: 2]))
        SVPS_F_START: d.start_o = 1'b1;
        SVPS_F_TRIP: begin
          d.start_o = 1'b1;
          d.trip_o = 1'b1;
        end
        SVPS_F_BLOCKED: d.blocked_o = 1'b1;
        default: d.start_o = 1'b0;
      endcase
    end else begin
      d.pickup_o = d.pickup;
      d.start_o = d.start;
      d.trip_o = d.trip;
      d.blocked_o = d.blocked;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= SVPS_IDLE;
      q.cfg <= {`SVPS_RST_PRIMNOM, `SVPS_RST_TIMING, `SVPS_RST_DT, `SVPS_RST_BANK, `SVPS_RST_BANK,
                `SVPS_RST_CTRL};
      q.expected <= 19'(`SVPS_RST_DT);
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.awready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = q.rdata;
  assign pickup        = q.pickup_o;
  assign start         = q.start_o;
  assign trip          = q.trip_o;
  assign blocked       = q.blocked_o;

endmodule // svps_stage

// ==== dv/svps_chk.sv ====
// svps_chk.sv: bus and status checker bound to the sequence voltage stage
`timescale 1ns/1ns
// ****************
// checker
// ****************
module svps_chk #(
  parameter int TICK_CYCLES = 20
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // stage status
  input wire logic        start,
  input wire logic        trip,
  input wire logic        blocked
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_aw_w_pair: assert property (s_axi_awready == s_axi_wready)
    else $error("address and data ready split");
  a_aw_one_cycle: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write ready held too long");
  a_b_answer: assert property (s_axi_awready && s_axi_awvalid && s_axi_wvalid |=> s_axi_bvalid)
    else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_answer: assert property (s_axi_arready && s_axi_arvalid |=> s_axi_rvalid)
    else $error("read data late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_r_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_trip_start: assert property (trip |-> start)
    else $error("trip without start");
  a_start_blocked: assert property (!(start && blocked))
    else $error("start and blocked together");
endmodule // svps_chk

bind svps_stage svps_chk #(.TICK_CYCLES(TICK_CYCLES)) i_svps_chk (.*);

// ==== dv/svps_src.sv ====
// svps_src.sv: model of the upstream phasor source
`timescale 1ns/1ns
// ****************
// phasor source
// ****************
module svps_src (
  // clock and request
  input wire logic               aclk,
  input wire logic               req,
  input wire logic signed [15:0] amp,
  input wire logic               rev,
  // phasors toward the stage
  output logic signed [15:0]     l1_re,
  output logic signed [15:0]     l1_im,
  output logic signed [15:0]     l2_re,
  output logic signed [15:0]     l2_im,
  output logic signed [15:0]     l3_re,
  output logic signed [15:0]     l3_im,
  output logic                   phasor_valid
);
  logic signed [15:0] s;
  initial {l1_re, l1_im, l2_re, l2_im, l3_re, l3_im, phasor_valid} = '0;
  // balanced set, rev swaps rotation; lines invert once after each set so stale data is never reused
  always @(posedge aclk) begin
    s = 16'($rtoi(0.8660254 * amp));
    phasor_valid <= req;
    if (req) begin
      l1_re <= amp;
      l1_im <= '0;
      l2_re <= -(amp >>> 1);
      l3_re <= -(amp >>> 1);
      l2_im <= rev ? s : -s;
      l3_im <= rev ? -s : s;
    end else if (phasor_valid) begin
      {l1_re, l1_im, l2_re, l2_im, l3_re, l3_im} <= ~{l1_re, l1_im, l2_re, l2_im, l3_re, l3_im};
    end
  end
endmodule // svps_src

// ==== dv/testbench.sv ====
// testbench.sv: register and stage behaviour tests of the sequence voltage stage
`timescale 1ns/1ns
`include "svps_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
// ****************
// testbench
// ****************
module testbench;
  import svps_pkg::*;
  localparam int TC = 20;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic signed [15:0] l1_re, l1_im, l2_re, l2_im, l3_re, l3_im, amp = '0;
  logic phasor_valid, req = 0, rev = 0, block_in = 0, active_group = 0;
  logic pickup, start, trip, blocked;
  logic [3:0][2:0] fx = {3'b001, 3'b110, 3'b100, 3'b000};
  int n_errors = 0, check_count = 0;

  always #5 aclk = ~aclk;
  svps_stage #(.TICK_CYCLES(TC)) i_svps_stage (.*);
  svps_src i_svps_src (.*);

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awready) begin aw = 1; s_axi_awvalid <= 0; end
      if (s_axi_wready) begin w = 1; s_axi_wvalid <= 0; end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  // one phasor set, then wait past the longest evaluation
  task automatic feed(input logic [15:0] v, input logic rv);
    @(posedge aclk);
    amp <= v;
    rev <= rv;
    req <= 1;
    @(posedge aclk);
    req <= 0;
    repeat (80) @(posedge aclk);
  endtask

  // magnitude carries a rounding error of a couple of counts
  function automatic logic near(input logic [15:0] g, input logic [15:0] e);
    return (g + 17'd2 >= {1'b0, e}) && (g <= e + 17'd2);
  endfunction

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    test_done;
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    rd(`SVPS_A_CTRL);
    `CHK(d, `SVPS_RST_CTRL)
    rd(`SVPS_A_BANK0);
    `CHK(d, `SVPS_RST_BANK)
    rd(`SVPS_A_TIMING);
    `CHK(d, `SVPS_RST_TIMING)
    rd(8'h1c);
    `CHK({r, d}, {`SVPS_SLVERR, 32'h0})
    wr(`SVPS_A_STATUS, 32'h0);
    `CHK(r, `SVPS_SLVERR)
    rd(`SVPS_A_PRIMPU);
    `CHK(d, 32'h0001_9a28)
    $display("test registers done");
    feed(16'd10000, 0);
    rd(`SVPS_A_MEAS);
    `CHK(near(d[15:0], 16'd10000), 1'b1)
    `CHK({d[31:16], pickup}, {16'd95, 1'b0})
    feed(16'd11000, 0);
    `CHK({pickup, start, trip}, 3'b110)
    repeat (8 * TC) @(posedge aclk);
    `CHK(trip, 1'b1)
    feed(16'd10300, 0);
    `CHK(pickup, 1'b1)
    feed(16'd10100, 0);
    `CHK({pickup, start}, 2'b01)
    repeat (14 * TC) @(posedge aclk);
    `CHK(start, 1'b0)
    wr(`SVPS_A_DT, 32'h0);
    feed(16'd11000, 0);
    `CHK({start, trip}, 2'b11)
    $display("test over mode done");
    wr(`SVPS_A_CTRL, 32'h11);
    feed(16'd11000, 1);
    `CHK(pickup, 1'b1)
    feed(16'd11000, 0);
    rd(`SVPS_A_MEAS);
    `CHK({pickup, near(d[15:0], 16'd0)}, 2'b01)
    $display("test sequence select done");
    wr(`SVPS_A_CTRL, 32'h12);
    feed(16'd10000, 0);
    `CHK(pickup, 1'b1)
    feed(16'd10700, 0);
    `CHK(pickup, 1'b1)
    feed(16'd11000, 0);
    `CHK(pickup, 1'b0)
    feed(16'd300, 0);
    rd(`SVPS_A_STATUS);
    `CHK({d[4], pickup, trip}, 3'b110)
    feed(16'd10000, 0);
    rd(`SVPS_A_STATUS);
    `CHK({d[4], trip}, 2'b10)
    feed(16'd11000, 0);
    rd(`SVPS_A_STATUS);
    `CHK(d[4], 1'b0)
    wr(`SVPS_A_BANK0, 32'h0000_2904);
    feed(16'd300, 0);
    rd(`SVPS_A_STATUS);
    `CHK({d[4], trip}, 2'b01)
    wr(`SVPS_A_BANK0, `SVPS_RST_BANK);
    wr(`SVPS_A_CTRL, 32'h10);
    feed(16'd300, 0);
    rd(`SVPS_A_STATUS);
    `CHK(d[4], 1'b0)
    $display("test under mode done");
    wr(`SVPS_A_BANK1, 32'h01f4_2328);
    active_group <= 1;
    feed(16'd10000, 0);
    rd(`SVPS_A_MEAS);
    `CHK({d[31:16], pickup}, {16'd111, 1'b1})
    rd(`SVPS_A_CTRL);
    `CHK(d, 32'h10)
    active_group <= 0;
    block_in <= 1;
    feed(16'd5000, 0);
    feed(16'd11000, 0);
    `CHK({start, blocked}, 2'b01)
    block_in <= 0;
    feed(16'd5000, 0);
    repeat (14 * TC) @(posedge aclk);
    $display("test group and block done");
    for (int f = 0; f < 4; f++) begin
      wr(`SVPS_A_CTRL, 32'h30 | (f << 6));
      `CHK({start, trip, blocked}, fx[f])
    end
    for (int m = 0; m < 5; m++) begin
      wr(`SVPS_A_CTRL, 32'h10 | (m << 8));
      rd(`SVPS_A_STATUS);
      `CHK(d[7:5], 3'(m))
    end
    $display("test force and mode done");
    wr(`SVPS_A_CTRL, 32'h18);
    feed(16'd11000, 0);
    rd(`SVPS_A_EXPECT);
    `CHK(d, 32'd250)
    repeat (4 * TC) @(posedge aclk);
    rd(`SVPS_A_REMAIN);
    `CHK(d < 32'd250 && d > 32'd240, 1'b1)
    feed(16'd12650, 0);
    rd(`SVPS_A_EXPECT);
    `CHK(d, 32'd50)
    $display("test operating time done");
    test_done;
  end
endmodule // testbench
